// >>> rtl/utc_pkg.sv
// Package: register map, field positions, reset values and types of the transmit control block
package utc_pkg;
   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] UTC_OFF_TXSTAT  = 12'h000;
   localparam logic [11:0] UTC_OFF_DATA    = 12'h004;
   localparam logic [11:0] UTC_OFF_IRQSTAT = 12'h008;
   localparam logic [11:0] UTC_OFF_IRQMASK = 12'h00C;
   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int UTC_B_CLKSRC = 7;
   localparam int UTC_B_NINE  = 6;
   localparam int UTC_B_TRANSMIT_ENABLE_BIT  = 5;
   localparam int UTC_B_SYNC  = 4;
   localparam int UTC_B_BREAK = 3;
   localparam int UTC_B_HIGH  = 2;
   localparam int UTC_B_EMPTY = 1;
   localparam int UTC_B_D9    = 0;
   localparam logic [7:0] UTC_CTRL_RESET = 8'h02;
   localparam logic [7:0] UTC_CTRL_WMASK = 8'hFD;
   // ---------------------------------------------------------------
   // Interrupt bits
   // ---------------------------------------------------------------
   localparam int UTC_IRQ_W      = 2;
   localparam int UTC_IRQ_DONE   = 0;
   localparam int UTC_IRQ_BRKEND = 1;
   // ---------------------------------------------------------------
   // Framing constants
   // ---------------------------------------------------------------
   localparam int          UTC_BREAK_BITS = 12;
   localparam logic [15:0] UTC_BAUD_DIV   = 16'h0010;
   localparam logic [3:0]  UTC_CNT_ZERO   = 4'h0;
   typedef enum logic [1:0] {UTC_IDLE, UTC_SHIFT} utc_state_t;
   typedef struct packed {
      logic       sync_mode;
      logic       nine_bit;
      logic       break_frame;
      logic [8:0] data;
   } utc_frame_t;
endpackage : utc_pkg

// >>> rtl/utc_shifter.sv
// Transmit shift register with bit timer, serialises one frame onto the line
`timescale 1ns/100ps
`default_nettype none
module utc_shifter
   import utc_pkg::*;
#(
   parameter logic [15:0] DIV = UTC_BAUD_DIV
) (
   input  wire logic       pclk,      // System clock
   input  wire logic       presetn,   // Async reset, active low
   input  wire logic       load,      // Start frame pulse
   input  wire utc_frame_t frame,     // Frame to send
   output logic            busy,      // Shift register loaded
   output logic            done,      // Frame finished pulse
   output logic            line,      // Serial output
   output logic            sclk       // Bit clock in synchronous mode
);
   logic [12:0] sh_reg;
   logic [3:0]  cnt_reg;
   logic [15:0] div_reg;
   logic        sync_reg;
   wire         tick = (div_reg == DIV - 16'h0001);
   wire         last = (cnt_reg == 4'h1);
   wire [3:0]   nbits_async = frame.nine_bit ? 4'hB : 4'hA;
   wire [3:0]   nbits_sync  = frame.nine_bit ? 4'h9 : 4'h8;
   wire [3:0]   nbits = frame.break_frame ? 4'(UTC_BREAK_BITS + 2) :
                        (frame.sync_mode ? nbits_sync : nbits_async);
   // Eight-bit frames put the stop bit where the ninth data bit would sit
   wire [8:0]   data_w = frame.nine_bit ? frame.data : {1'b1, frame.data[7:0]};
   // Break: start bit plus twelve zeros; the stop bit is a one shifted in at the top
   wire [12:0]  word_async = frame.break_frame ? 13'h0000 :
                             {3'h7, data_w, 1'b0};
   wire [12:0]  word = frame.sync_mode ? {4'hF, frame.data} : word_async;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_reg   <= 13'h1FFF;
         cnt_reg  <= UTC_CNT_ZERO;
         div_reg  <= 16'h0000;
         busy     <= 1'b0;
         done     <= 1'b0;
         line     <= 1'b1;
         sclk     <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load && !busy) begin
            sh_reg   <= word;
            cnt_reg  <= nbits;
            div_reg  <= 16'h0000;
            busy     <= 1'b1;
            sync_reg <= frame.sync_mode;
            line     <= word[0];
            sclk     <= 1'b0;
         end else if (busy) begin
            div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
            sclk    <= sync_reg && (div_reg >= (DIV >> 1));
            if (tick) begin
               sh_reg  <= {1'b1, sh_reg[12:1]};
               cnt_reg <= cnt_reg - 4'h1;
               line    <= last ? 1'b1 : sh_reg[1];
               if (last) begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
         end else begin
            // Bit clock rests low between frames
            sclk <= 1'b0;
         end
      end
   end
endmodule : utc_shifter
`default_nettype wire

// >>> rtl/utc_top.sv
// Transmit status and control register with APB slave, interrupt and frame control
//
// How it works
// [RULE1] Bit 4 set selects synchronous framing, clear selects asynchronous framing.
// [RULE2] Bit 5 gates the transmitter: frames start only while it is one.
// [RULE3] In asynchronous mode a set break bit turns the next transmission into a break frame.
// [RULE4] Hardware clears the break bit once the break frame has fully left the line.
// [RULE5] Bit 1 is read only, one while the shift register is empty, and resets to one.
`timescale 1ns/100ps
`default_nettype none
module utc_top
   import utc_pkg::*;
#(
   parameter logic [15:0] DIV = UTC_BAUD_DIV
) (
   input  wire logic        pclk,     // System clock
   input  wire logic        presetn,  // Async reset, active low
   input  wire logic        psel,     // APB select
   input  wire logic        penable,  // APB access phase
   input  wire logic        pwrite,   // APB direction
   input  wire logic [11:0] paddr,    // APB byte address
   input  wire logic [31:0] pwdata,   // APB write data
   output logic      [31:0] prdata,   // APB read data
   output logic             pready,   // APB ready
   output logic             pslverr,  // APB error
   output logic             irq,      // Interrupt level
   output logic             tx_line,  // Serial data out
   output logic             tx_clk    // Bit clock out, synchronous mode
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0]           ctrl_reg;
   logic [8:0]           data_reg;
   logic                 pend_reg;
   logic                 brk_active_reg;
   logic [UTC_IRQ_W-1:0] ista_reg;
   logic [UTC_IRQ_W-1:0] imask_reg;
   utc_state_t           st_reg;
   logic                 busy;
   logic                 done;
   logic                 line_w;
   logic                 sclk_w;
   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire access  = psel && penable;
   wire wr      = access && pwrite;
   wire sel_ctl = (paddr == UTC_OFF_TXSTAT);
   wire sel_dat = (paddr == UTC_OFF_DATA);
   wire sel_ist = (paddr == UTC_OFF_IRQSTAT);
   wire sel_imk = (paddr == UTC_OFF_IRQMASK);
   wire mapped  = sel_ctl || sel_dat || sel_ist || sel_imk;
   wire wr_ctl  = wr && sel_ctl;
   wire wr_dat  = wr && sel_dat;
   wire wr_ist  = wr && sel_ist;
   wire wr_imk  = wr && sel_imk;
   // ---------------------------------------------------------------
   // Frame launch
   // ---------------------------------------------------------------
   wire sync_mode = ctrl_reg[UTC_B_SYNC];                        // [RULE1]
   wire tx_on     = ctrl_reg[UTC_B_TRANSMIT_ENABLE_BIT];                        // [RULE2]
   wire brk_req   = ctrl_reg[UTC_B_BREAK] && !sync_mode;         // [RULE3]
   wire launch    = tx_on && pend_reg && !busy && (st_reg == UTC_IDLE); // [RULE2]
   wire utc_frame_t frame_w;
   assign frame_w.sync_mode   = sync_mode;                       // [RULE1]
   assign frame_w.nine_bit    = ctrl_reg[UTC_B_NINE];
   assign frame_w.break_frame = brk_req;                         // [RULE3]
   assign frame_w.data        = data_reg;
   wire brk_done = done && brk_active_reg;                       // [RULE4]
   wire [UTC_IRQ_W-1:0] events;
   assign events[UTC_IRQ_DONE]   = done;
   assign events[UTC_IRQ_BRKEND] = brk_done;
   wire [7:0] status_rd = {ctrl_reg[UTC_B_CLKSRC:UTC_B_HIGH], !busy, ctrl_reg[UTC_B_D9]}; // [RULE5]
   wire [31:0] rd_mux = sel_ctl ? {24'h000000, status_rd} :
                        sel_dat ? {23'h000000, data_reg} :
                        sel_ist ? {30'h00000000, ista_reg} :
                        sel_imk ? {30'h00000000, imask_reg} : 32'h00000000;
   // Software may not set the read-only empty bit
   wire [7:0] ctl_wr = (pwdata[7:0] & UTC_CTRL_WMASK) | (ctrl_reg & ~UTC_CTRL_WMASK);
   // Hardware clear of the break bit takes priority over a same-cycle rewrite
   wire [7:0] ctl_next = brk_done ? (ctl_wr & ~(8'h01 << UTC_B_BREAK)) : ctl_wr;

   utc_shifter #(.DIV(DIV)) i_utc_shifter (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (launch),
      .frame   (frame_w),
      .busy    (busy),
      .done    (done),
      .line    (line_w),
      .sclk    (sclk_w)
   );
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= UTC_CTRL_RESET;                             // [RULE5]
      end else if (wr_ctl) begin
         ctrl_reg <= ctl_next;
      end else if (brk_done) begin
         ctrl_reg[UTC_B_BREAK] <= 1'b0;                          // [RULE4]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_reg       <= 9'h000;
         pend_reg       <= 1'b0;
         brk_active_reg <= 1'b0;
         st_reg         <= UTC_IDLE;
      end else begin
         if (wr_dat) begin
            data_reg <= {ctrl_reg[UTC_B_D9], pwdata[7:0]};
         end
         case (st_reg)
            UTC_IDLE: begin
               if (launch) begin
                  st_reg         <= UTC_SHIFT;
                  brk_active_reg <= brk_req;                     // [RULE3]
               end
            end
            UTC_SHIFT: begin
               if (done) begin
                  st_reg         <= UTC_IDLE;
                  brk_active_reg <= 1'b0;
               end
            end
            default: st_reg <= UTC_IDLE;
         endcase
         // A break consumes the launch but leaves the data word pending
         if (wr_dat) begin
            pend_reg <= 1'b1;
         end else if (launch && !brk_req) begin
            pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ista_reg  <= '0;
         imask_reg <= '0;
      end else begin
         ista_reg <= (wr_ist ? (ista_reg & ~pwdata[UTC_IRQ_W-1:0]) : ista_reg) | events;
         if (wr_imk) begin
            imask_reg <= pwdata[UTC_IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
         tx_line <= 1'b1;
         tx_clk  <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
         irq     <= |(ista_reg & imask_reg);
         tx_line <= line_w;
         tx_clk  <= sclk_w;
      end
   end
endmodule : utc_top
`default_nettype wire

// >>> sim/utc_assertions.sv
// Checker: port-level properties of the transmit control block
`timescale 1ns/100ps
`default_nettype none
module utc_assertions
   import utc_pkg::*;
#(
   parameter logic [15:0] DIV = UTC_BAUD_DIV
) (
   input wire logic        pclk,     // Clock
   input wire logic        presetn,  // Reset, active low
   input wire logic        psel,     // Select
   input wire logic        penable,  // Access phase
   input wire logic        pwrite,   // Direction
   input wire logic [11:0] paddr,    // Address
   input wire logic [31:0] pwdata,   // Write data
   input wire logic [31:0] prdata,   // Read data
   input wire logic        pready,   // Ready
   input wire logic        pslverr,  // Error
   input wire logic        irq,      // Interrupt
   input wire logic        tx_line,  // Serial out
   input wire logic        tx_clk    // Bit clock
);
   // ---------------------------------------------------------------
   // Shadow of written control and mask, length of low runs
   // ---------------------------------------------------------------
   logic [7:0]  ctrl_q;
   logic [7:0]  mask_q;
   logic [15:0] low_cnt;
   wire         wr_ok = psel & penable & pready & pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= 8'h00;
         mask_q  <= 8'h00;
         low_cnt <= 16'h0000;
      end else begin
         if (wr_ok && paddr == UTC_OFF_TXSTAT) ctrl_q <= pwdata[7:0];
         if (wr_ok && paddr == UTC_OFF_IRQMASK) mask_q <= pwdata[7:0];
         low_cnt <= tx_line ? 16'h0000 : low_cnt + 16'h0001;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready late");
   property p_only; pready |-> psel && penable; endproperty
   a_only: assert property (p_only) else $error("pready outside access");
   property p_err; pready && paddr > UTC_OFF_IRQMASK |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no error on unmapped");
   property p_zero; !pready |-> prdata == 32'h0000_0000; endproperty
   a_zero: assert property (p_zero) else $error("read data outside access");
   property p_irq; irq |-> $past(mask_q[UTC_IRQ_W-1:0]) != '0; endproperty
   a_irq: assert property (p_irq) else $error("irq while all masked");
   property p_sync; !ctrl_q[UTC_B_SYNC] && !$past(ctrl_q[UTC_B_SYNC]) |-> !tx_clk; endproperty
   a_sync: assert property (p_sync) else $error("bit clock in async mode");
   property p_transmit_enable_bit; $fell(tx_line) |-> $past(ctrl_q[UTC_B_TRANSMIT_ENABLE_BIT]); endproperty
   a_transmit_enable_bit: assert property (p_transmit_enable_bit) else $error("frame while disabled");
   property p_brk; low_cnt <= 16'(13) * DIV; endproperty
   a_brk: assert property (p_brk) else $error("line low too long");
   property p_empty;
      pready && !pwrite && paddr == UTC_OFF_TXSTAT && !tx_line && !ctrl_q[UTC_B_SYNC]
      |-> !prdata[UTC_B_EMPTY];
   endproperty
   a_empty: assert property (p_empty) else $error("empty while shifting");
endmodule : utc_assertions
`default_nettype wire

// >>> sim/utc_peer.sv
// Serial peer model: takes asynchronous frames, counts bit clocks
`timescale 1ns/100ps
`default_nettype none
module utc_peer #(
   parameter int DIV = 4
) (
   input wire logic pclk,  // System clock
   input wire logic line,  // Serial data in
   input wire logic sclk   // Bit clock in
);
   logic [7:0] rx_byte;
   int         frames     = 0;
   int         breaks     = 0;
   int         sclk_edges = 0;
   always @(posedge sclk) sclk_edges++;
   // Mid-bit sampling; a low stop slot marks a break
   always begin
      @(negedge line);
      repeat (DIV / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge pclk);
         rx_byte[i] = line;
      end
      repeat (DIV) @(posedge pclk);
      if (line) frames++;
      else begin
         breaks++;
         wait (line);
      end
   end
endmodule : utc_peer
`default_nettype wire

// >>> sim/utc_top_tb_top.sv
// Testbench top: APB tasks, frame scenarios and verdict
`timescale 1ns/100ps
`default_nettype none
module utc_top_tb_top;
   import utc_pkg::*;
   localparam logic [15:0] DIV = 16'h0004;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, irq, tx_line, tx_clk, last_err;
   int          failures = 0, num_checks = 0;
   always #2 pclk = ~pclk;
   utc_top #(.DIV(DIV)) i_utc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .tx_line(tx_line), .tx_clk(tx_clk));
   utc_peer #(.DIV(int'(DIV))) i_utc_peer (.pclk(pclk), .line(tx_line), .sclk(tx_clk));
   task automatic stop_test;
      if (failures == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   // One idle cycle after each transfer keeps drivers single per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait for the answer
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      check(nm, q, exp);
   endtask : rd
   task automatic wait_irq;
      for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge pclk);
   endtask : wait_irq
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd("ctrl_reset", UTC_OFF_TXSTAT, 32'h02);
      check("mapped_err", {31'h0, last_err}, 32'h0);
      wr(UTC_OFF_TXSTAT, 32'hFD);
      rd("ctrl_all", UTC_OFF_TXSTAT, 32'hFF);
      wr(UTC_OFF_TXSTAT, 32'h00);
      rd("ctrl_ro", UTC_OFF_TXSTAT, 32'h02);
      rd("unmapped", 12'h010, 32'h0);
      check("unmapped_err", {31'h0, last_err}, 32'h1);
      wr(UTC_OFF_IRQMASK, 32'h03);
      wr(UTC_OFF_DATA, 32'h3C);
      repeat (15 * DIV) @(posedge pclk);
      check("held_frames", 32'(i_utc_peer.frames), 32'h0);
      wr(UTC_OFF_TXSTAT, 32'h20);
      rd("ctrl_busy", UTC_OFF_TXSTAT, 32'h20);
      wait_irq();
      check("irq_level", {31'h0, irq}, 32'h1);
      check("rx_byte", {24'h0, i_utc_peer.rx_byte}, 32'h3C);
      rd("irq_done", UTC_OFF_IRQSTAT, 32'h01);
      wr(UTC_OFF_IRQSTAT, 32'h01);
      rd("irq_clr", UTC_OFF_IRQSTAT, 32'h00);
      wr(UTC_OFF_TXSTAT, 32'h28);
      wr(UTC_OFF_DATA, 32'h55);
      rd("brk_set", UTC_OFF_TXSTAT, 32'h28);
      for (int n = 0; n < 3000 && i_utc_peer.frames < 2; n++) @(posedge pclk);
      check("breaks", 32'(i_utc_peer.breaks), 32'h1);
      check("after_brk", {24'h0, i_utc_peer.rx_byte}, 32'h55);
      repeat (4 * DIV) @(posedge pclk);
      rd("brk_clr", UTC_OFF_TXSTAT, 32'h22);
      rd("irq_both", UTC_OFF_IRQSTAT, 32'h03);
      wr(UTC_OFF_IRQSTAT, 32'h03);
      wr(UTC_OFF_TXSTAT, 32'h61);
      wr(UTC_OFF_DATA, 32'hA5);
      wait_irq();
      check("nine_irq", {31'h0, irq}, 32'h1);
      check("nine_byte", {24'h0, i_utc_peer.rx_byte}, 32'hA5);
      check("nine_frames", 32'(i_utc_peer.frames), 32'h3);
      check("nine_breaks", 32'(i_utc_peer.breaks), 32'h1);
      wr(UTC_OFF_IRQSTAT, 32'h01);
      wr(UTC_OFF_TXSTAT, 32'h30);
      wr(UTC_OFF_DATA, 32'h81);
      wait_irq();
      check("irq_sync", {31'h0, irq}, 32'h1);
      check("sync_clks", 32'(i_utc_peer.sclk_edges), 32'h8);
      stop_test();
   end
   initial begin
      #40000;
      failures++;
      stop_test();
   end
endmodule : utc_top_tb_top
bind utc_top utc_assertions #(.DIV(DIV)) i_utc_assertions (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .tx_line(tx_line),
   .tx_clk(tx_clk));
`default_nettype wire
